// ===== see_consts.vh
`ifndef SEE_CONSTS_VH
`define SEE_CONSTS_VH

// device address word
`define SEE_DEV_CODE 4'hA
`define SEE_DIR_READ 1'b1

// variants: data word address width and page offset width
`define SEE_AW_SMALL 14
`define SEE_AW_MID 15
`define SEE_AW_LARGE 16
`define SEE_PW_SMALL 6
`define SEE_PW_LARGE 7
`define SEE_PAGE_MAX 128

// serial framing
`define SEE_WORD_BITS 4'h8
`define SEE_LAST_BIT 4'h7
`define SEE_ACK_BIT 4'h8
`define SEE_START_CNT 4'hF

// timing
`define SEE_CLK_KHZ 10000
`define SEE_T_WR_US 5000
`define SEE_WR_CYCLES ((`SEE_T_WR_US * `SEE_CLK_KHZ) / 1000)

// buffer entry: page offset plus data byte
`define SEE_BUF_W 15

`endif

// ===== see_buf2.v
`timescale 1ns/1ns
`include "see_consts.vh"

module see_buf2 (
    // clock and reset
    input wire sys_clk,
    input wire reset_n,
    // fill side
    input wire inValid,
    output wire inReady,
    input wire [`SEE_BUF_W-1:0] inData,
    // drain side
    output wire outValid,
    input wire outReady,
    output wire [`SEE_BUF_W-1:0] outData
);
    reg [`SEE_BUF_W-1:0] slot_ff [0:1];
    reg wrPtr_ff;
    reg rdPtr_ff;
    reg [1:0] count_ff;
    wire push;
    wire pop;

    assign inReady = (count_ff != 2'h2);
    assign outValid = (count_ff != 2'h0);
    assign outData = slot_ff[rdPtr_ff];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    always @(posedge sys_clk) begin
        if (push) begin
            slot_ff[wrPtr_ff] <= inData;
        end
    end

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            wrPtr_ff <= 1'b0;
            rdPtr_ff <= 1'b0;
            count_ff <= 2'h0;
        end else begin
            if (push) begin
                wrPtr_ff <= ~wrPtr_ff;
            end
            if (pop) begin
                rdPtr_ff <= ~rdPtr_ff;
            end
            if (push & !pop) begin
                count_ff <= count_ff + 2'h1;
            end else if (pop & !push) begin
                count_ff <= count_ff - 2'h1;
            end
        end
    end
endmodule

// ===== see_slave.v
`timescale 1ns/1ns
`include "see_consts.vh"

module see_slave #(
    parameter ADDR_W = `SEE_AW_LARGE,
    parameter [31:0] WR_CYCLES = `SEE_WR_CYCLES
) (
    // clock and reset
    input wire sys_clk,
    input wire reset_n,
    // two-wire bus
    input wire scl,
    input wire sdaIn,
    output wire sdaOut,
    output wire sdaOe,
    // straps
    input wire [2:0] deviceSelectPins,
    input wire writeProtect,
    // status
    output wire standby,
    output wire writeBusy
);
    localparam PAGE_W = (ADDR_W == `SEE_AW_LARGE) ? `SEE_PW_LARGE : `SEE_PW_SMALL;
    localparam [15:0] ADDR_MASK = 16'hFFFF >> (16 - ADDR_W);
    localparam [15:0] PAGE_MASK = 16'h00FF >> (8 - PAGE_W);
    localparam [6:0] OFF_MASK = 7'h7F >> (7 - PAGE_W);
    localparam [15:0] MEM_DEPTH = ADDR_MASK;

    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_DEV = 7'h02;
    localparam [6:0] ST_ADRH = 7'h04;
    localparam [6:0] ST_ADRL = 7'h08;
    localparam [6:0] ST_WDATA = 7'h10;
    localparam [6:0] ST_RDATA = 7'h20;
    localparam [6:0] ST_IGNORE = 7'h40;

    // full-array increment, used for reads and the counter after a read
    function [15:0] incAddr;
        input [15:0] a;
        begin
            incAddr = (a + 16'h0001) & ADDR_MASK;
        end
    endfunction

    // page-local increment: upper bits keep the page row
    function [15:0] incPage;
        input [15:0] a;
        begin
            incPage = (a & ~PAGE_MASK) | ((a + 16'h0001) & PAGE_MASK);
        end
    endfunction

    reg [7:0] mem [0:MEM_DEPTH];
    reg [7:0] pageData [0:`SEE_PAGE_MAX-1];

    // pin synchronisers
    reg sclS1_ff;
    reg sclS2_ff;
    reg sclD_ff;
    reg sdaS1_ff;
    reg sdaS2_ff;
    reg sdaD_ff;
    reg [2:0] selS1_ff;
    reg [2:0] selS2_ff;
    reg wpS1_ff;
    reg wpS2_ff;

    reg [6:0] state_ff;
    reg [3:0] bitCnt_ff;
    reg [7:0] shReg_ff;
    reg [7:0] txByte_ff;
    reg [7:0] addrHi_ff;
    reg [15:0] addrCnt_ff;
    reg oe_ff;
    reg ackOk_ff;
    reg masterAck_ff;
    reg [`SEE_PAGE_MAX-1:0] pageMask_ff;
    reg commitReq_ff;
    reg busy_ff;
    reg [31:0] wrCnt_ff;
    reg standby_ff;

    wire sclRise;
    wire sclFall;
    wire startCond;
    wire stopCond;
    wire devMatch;
    wire bufInReady;
    wire bufOutValid;
    wire [`SEE_BUF_W-1:0] bufOutData;
    wire bufPush;
    wire drainReady;
    wire wrDone;
    wire [6:0] wrOff;
    wire [15:0] nxt_addrCnt;
    integer i;

    assign sclRise = sclS2_ff & !sclD_ff;
    assign sclFall = !sclS2_ff & sclD_ff;
    assign startCond = sclS2_ff & sclD_ff & sdaD_ff & !sdaS2_ff;
    assign stopCond = sclS2_ff & sclD_ff & !sdaD_ff & sdaS2_ff;
    // floating select pins are biased low on the board side before reaching us
    assign devMatch = (shReg_ff[7:4] == `SEE_DEV_CODE)
        & (shReg_ff[3:1] == selS2_ff)
        & !busy_ff;
    assign wrOff = addrCnt_ff[6:0] & OFF_MASK;
    assign bufPush = sclFall & (bitCnt_ff == `SEE_LAST_BIT) & (state_ff == ST_WDATA);
    // the page latch is not touched while the array copies it
    assign drainReady = !busy_ff;
    assign wrDone = busy_ff & (wrCnt_ff == WR_CYCLES - 32'h1);
    assign nxt_addrCnt = incAddr(addrCnt_ff);

    assign sdaOut = 1'b0;
    assign sdaOe = oe_ff;
    assign standby = standby_ff;
    assign writeBusy = busy_ff;

    see_buf2 see_buf2_i (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .inValid(bufPush),
        .inReady(bufInReady),
        .inData({wrOff, shReg_ff}),
        .outValid(bufOutValid),
        .outReady(drainReady),
        .outData(bufOutData)
    );

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            sclS1_ff <= 1'b1;
            sclS2_ff <= 1'b1;
            sclD_ff <= 1'b1;
            sdaS1_ff <= 1'b1;
            sdaS2_ff <= 1'b1;
            sdaD_ff <= 1'b1;
            selS1_ff <= 3'h0;
            selS2_ff <= 3'h0;
            wpS1_ff <= 1'b0;
            wpS2_ff <= 1'b0;
        end else begin
            sclS1_ff <= scl;
            sclS2_ff <= sclS1_ff;
            sclD_ff <= sclS2_ff;
            sdaS1_ff <= sdaIn;
            sdaS2_ff <= sdaS1_ff;
            sdaD_ff <= sdaS2_ff;
            selS1_ff <= deviceSelectPins;
            selS2_ff <= selS1_ff;
            wpS1_ff <= writeProtect;
            wpS2_ff <= wpS1_ff;
        end
    end

    // page latch fill from the buffer
    always @(posedge sys_clk) begin
        if (bufOutValid & drainReady) begin
            pageData[bufOutData[14:8]] <= bufOutData[7:0];
        end
    end

    // array commit at the end of the timed write
    always @(posedge sys_clk) begin
        if (wrDone) begin
            for (i = 0; i < `SEE_PAGE_MAX; i = i + 1) begin
                if (pageMask_ff[i]) begin
                    mem[(addrCnt_ff & ~PAGE_MASK) | (i[15:0] & PAGE_MASK)] <= pageData[i];
                end
            end
        end
    end

    // timed write cycle
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            busy_ff <= 1'b0;
            wrCnt_ff <= 32'h0;
            commitReq_ff <= 1'b0;
            standby_ff <= 1'b1;
        end else begin
            if (busy_ff) begin
                wrCnt_ff <= wrCnt_ff + 32'h1;
                if (wrDone) begin
                    busy_ff <= 1'b0;
                end
            end else if (commitReq_ff & !bufOutValid) begin
                commitReq_ff <= 1'b0;
                if (!wpS2_ff && pageMask_ff != {`SEE_PAGE_MAX{1'b0}}) begin
                    busy_ff <= 1'b1;
                    wrCnt_ff <= 32'h0;
                end
            end else if (stopCond && state_ff == ST_WDATA) begin
                commitReq_ff <= 1'b1;
            end
            standby_ff <= !busy_ff & !commitReq_ff
                & ((state_ff == ST_IDLE) | (state_ff == ST_IGNORE));
        end
    end

    // serial protocol engine
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
            bitCnt_ff <= 4'h0;
            shReg_ff <= 8'h00;
            txByte_ff <= 8'h00;
            addrHi_ff <= 8'h00;
            addrCnt_ff <= 16'h0000;
            oe_ff <= 1'b0;
            ackOk_ff <= 1'b0;
            masterAck_ff <= 1'b0;
            pageMask_ff <= {`SEE_PAGE_MAX{1'b0}};
        end else if (busy_ff | commitReq_ff) begin
            // deaf while writing: no ack, no framing, only polls wait
            state_ff <= ST_IDLE;
            oe_ff <= 1'b0;
            bitCnt_ff <= 4'h0;
            if (wrDone) begin
                pageMask_ff <= {`SEE_PAGE_MAX{1'b0}};
            end
        end else if (startCond) begin
            state_ff <= ST_DEV;
            // the start's own scl fall wraps this to zero, so it is not counted as a bit
            bitCnt_ff <= `SEE_START_CNT;
            oe_ff <= 1'b0;
        end else if (stopCond) begin
            state_ff <= ST_IDLE;
            oe_ff <= 1'b0;
            if (state_ff != ST_WDATA) begin
                pageMask_ff <= {`SEE_PAGE_MAX{1'b0}};
            end
        end else begin
            if (bufOutValid & drainReady) begin
                pageMask_ff[bufOutData[14:8]] <= 1'b1;
            end
            case (state_ff)
                ST_DEV, ST_ADRH, ST_ADRL, ST_WDATA: begin
                    if (sclRise && bitCnt_ff < `SEE_WORD_BITS) begin
                        shReg_ff <= {shReg_ff[6:0], sdaS2_ff};
                    end else if (sclFall && bitCnt_ff == `SEE_LAST_BIT) begin
                        bitCnt_ff <= `SEE_ACK_BIT;
                        case (state_ff)
                            ST_DEV: begin
                                ackOk_ff <= devMatch;
                                oe_ff <= devMatch;
                            end
                            ST_ADRH: begin
                                addrHi_ff <= shReg_ff;
                                ackOk_ff <= 1'b1;
                                oe_ff <= 1'b1;
                            end
                            ST_ADRL: begin
                                addrCnt_ff <= {addrHi_ff, shReg_ff} & ADDR_MASK;
                                pageMask_ff <= {`SEE_PAGE_MAX{1'b0}};
                                ackOk_ff <= 1'b1;
                                oe_ff <= 1'b1;
                            end
                            ST_WDATA: begin
                                // a full buffer refuses the byte by withholding the ack
                                ackOk_ff <= bufInReady;
                                oe_ff <= bufInReady;
                                if (bufInReady) begin
                                    addrCnt_ff <= incPage(addrCnt_ff);
                                end
                            end
                            default: begin
                                ackOk_ff <= 1'b0;
                                oe_ff <= 1'b0;
                            end
                        endcase
                    end else if (sclFall && bitCnt_ff == `SEE_ACK_BIT) begin
                        bitCnt_ff <= 4'h0;
                        oe_ff <= 1'b0;
                        case (state_ff)
                            ST_DEV: begin
                                if (!ackOk_ff) begin
                                    state_ff <= ST_IGNORE;
                                end else if (shReg_ff[0] == `SEE_DIR_READ) begin
                                    state_ff <= ST_RDATA;
                                    txByte_ff <= mem[addrCnt_ff];
                                    oe_ff <= !mem[addrCnt_ff][7];
                                end else begin
                                    state_ff <= ST_ADRH;
                                end
                            end
                            ST_ADRH: begin
                                state_ff <= ST_ADRL;
                            end
                            ST_ADRL: begin
                                state_ff <= ST_WDATA;
                            end
                            ST_WDATA: begin
                                state_ff <= ackOk_ff ? ST_WDATA : ST_IGNORE;
                            end
                            default: begin
                                state_ff <= ST_IGNORE;
                            end
                        endcase
                    end else if (sclFall) begin
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                    end
                end
                ST_RDATA: begin
                    if (sclFall && bitCnt_ff < `SEE_LAST_BIT) begin
                        txByte_ff <= {txByte_ff[6:0], 1'b0};
                        oe_ff <= !txByte_ff[6];
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                    end else if (sclFall && bitCnt_ff == `SEE_LAST_BIT) begin
                        oe_ff <= 1'b0;
                        bitCnt_ff <= `SEE_ACK_BIT;
                        addrCnt_ff <= nxt_addrCnt;
                    end else if (sclRise && bitCnt_ff == `SEE_ACK_BIT) begin
                        masterAck_ff <= !sdaS2_ff;
                    end else if (sclFall && bitCnt_ff == `SEE_ACK_BIT) begin
                        bitCnt_ff <= 4'h0;
                        if (masterAck_ff) begin
                            txByte_ff <= mem[addrCnt_ff];
                            oe_ff <= !mem[addrCnt_ff][7];
                        end else begin
                            state_ff <= ST_IGNORE;
                            oe_ff <= 1'b0;
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    oe_ff <= 1'b0;
                end
                default: begin
                    state_ff <= ST_IDLE;
                    oe_ff <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ===== see_slave_properties.sv
`timescale 1ns/1ns
module see_slave_properties #(
    parameter [31:0] WR_CYCLES = 32'h0000C350
) (
    // clock and reset
    input wire sys_clk,
    input wire reset_n,
    // bus and straps
    input wire scl,
    input wire sdaIn,
    input wire sdaOut,
    input wire sdaOe,
    input wire writeProtect,
    // status
    input wire standby,
    input wire writeBusy
);
    logic [31:0] busyCnt_ff;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // counts sampled busy cycles; cleared whenever the write cycle is not running
    always @(posedge sys_clk) begin
        if (!reset_n || !writeBusy) busyCnt_ff <= 32'h0;
        else busyCnt_ff <= busyCnt_ff + 32'h1;
    end
    sequence startSeen;
        scl && $past(scl) && $fell(sdaIn);
    endsequence
    sequence stopSeen;
        scl && $past(scl) && $rose(sdaIn);
    endsequence
    a_open_drain: assert property (sdaOut == 1'b0)
        else $error("sda driven high");
    a_oe_scl_low: assert property ($changed(sdaOe) |-> !scl)
        else $error("sda drive changed while scl high");
    a_start_quiet: assert property (startSeen |-> !sdaOe [*8])
        else $error("sda driven right after start");
    a_stop_settle: assert property (stopSeen |-> ##[1:8] (standby || writeBusy))
        else $error("no standby or write after stop");
    a_busy_deaf: assert property (writeBusy |-> !sdaOe)
        else $error("sda driven during write cycle");
    a_busy_standby: assert property (writeBusy |-> !standby)
        else $error("standby during write cycle");
    a_busy_length: assert property ($fell(writeBusy) |-> busyCnt_ff == WR_CYCLES)
        else $error("write cycle length wrong");
    a_busy_bound: assert property (busyCnt_ff <= WR_CYCLES)
        else $error("write cycle too long");
    a_protect_hold: assert property ($rose(writeBusy) |-> !writeProtect)
        else $error("write cycle while protected");
    a_done_standby: assert property ($fell(writeBusy) |-> ##[0:2] standby)
        else $error("no standby after write cycle");
endmodule
bind see_slave see_slave_properties #(.WR_CYCLES(WR_CYCLES)) see_slave_properties_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .writeProtect(writeProtect), .standby(standby), .writeBusy(writeBusy));

// ===== see_bus_master.sv
`timescale 1ns/1ns
module see_bus_master (
    // bus pins
    output logic scl,
    output logic sdaLow,
    input wire sda
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // clock stands high between frames; data moves only while it is low
    // every pin delay is a whole number of half periods of the bench clock, so each change lands on a bench clock edge or 1 ns after one
    task automatic bitOut(input logic b);
        #50 sdaLow = !b;
        #400 scl = 1'b1;
        #300 scl = 1'b0;
        #50;
    endtask
    // device answers late in the low phase, so sample near the end of high
    task automatic bitIn(output logic b);
        #50 sdaLow = 1'b0;
        #400 scl = 1'b1;
        #200 b = sda;
        #100 scl = 1'b0;
        #50;
    endtask
    task automatic start;
        #50 sdaLow = 1'b0;
        #400 scl = 1'b1;
        #200 sdaLow = 1'b1;
        #200 scl = 1'b0;
        #50;
    endtask
    task automatic stop;
        #50 sdaLow = 1'b1;
        #400 scl = 1'b1;
        #200 sdaLow = 1'b0;
        #450;
    endtask
    task automatic byteOut(input logic [7:0] d, output logic ack);
        logic a;
        int i;
        for (i = 7; i >= 0; i--) bitOut(d[i]);
        bitIn(a);
        ack = !a; // low in the ninth clock acknowledges
    endtask
    task automatic byteIn(output logic [7:0] d, input logic ack);
        int i;
        for (i = 7; i >= 0; i--) bitIn(d[i]);
        bitOut(!ack);
    endtask
    task automatic recover;
        logic b;
        int i;
        b = 1'b0;
        for (i = 0; i < 9 && !b; i++) bitIn(b);
        start();
        stop();
    endtask
endmodule

// ===== see_slave_tb.sv
`timescale 1ns/1ns
module see_slave_tb;
    localparam logic [2:0] SEL = 3'h5;
    logic sys_clk;
    logic reset_n;
    logic writeProtect;
    logic [2:0] deviceSelectPins;
    wire scl;
    wire sdaLow;
    wire sdaOut;
    wire sdaOe;
    wire sda;
    wire standby;
    wire writeBusy;
    int failures = 0;
    int testsRun = 0;
    int cycles = 0;
    // pull-up wire: any party pulling low wins
    assign sda = !(sdaLow || (sdaOe && !sdaOut));
    see_slave #(.ADDR_W(16), .WR_CYCLES(20)) see_slave_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .deviceSelectPins(deviceSelectPins), .writeProtect(writeProtect),
        .standby(standby), .writeBusy(writeBusy));
    see_bus_master see_bus_master_i (.scl(scl), .sdaLow(sdaLow), .sda(sda));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic printVerdict;
        if (failures == 0 && testsRun > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic send(input logic [7:0] d, input logic expAck);
        logic ack;
        see_bus_master_i.byteOut(d, ack);
        check({7'h00, ack}, {7'h00, expAck});
    endtask
    task automatic waitIdle;
        int i;
        for (i = 0; i < 100 && writeBusy !== 1'b0; i++) @(posedge sys_clk);
        repeat (3) @(posedge sys_clk);
        #1 check({7'h00, standby}, 8'h01);
    endtask
    task automatic setAddr(input logic [15:0] addr);
        see_bus_master_i.start();
        send({4'hA, SEL, 1'b0}, 1'b1);
        send(addr[15:8], 1'b1);
        send(addr[7:0], 1'b1);
    endtask
    task automatic readBack(input logic [15:0] addr, input logic [23:0] exp, input int n);
        logic [7:0] d;
        int i;
        setAddr(addr);
        see_bus_master_i.start();
        send({4'hA, SEL, 1'b1}, 1'b1);
        for (i = 0; i < n; i++) begin
            see_bus_master_i.byteIn(d, i < n - 1);
            check(d, exp[23 - 8 * i -: 8]);
        end
        see_bus_master_i.stop();
        waitIdle();
    endtask
    task automatic byteWritePoll;
        setAddr(16'h1234);
        send(8'hA5, 1'b1);
        see_bus_master_i.stop();
        repeat (10) @(posedge sys_clk);
        #1 check({7'h00, writeBusy}, 8'h01);
        see_bus_master_i.start();
        send({4'hA, SEL, 1'b0}, 1'b0);
        see_bus_master_i.stop();
        waitIdle();
        see_bus_master_i.start();
        send({4'hA, SEL, 1'b0}, 1'b1);
        see_bus_master_i.stop();
        readBack(16'h1234, 24'hA50000, 1);
    endtask
    task automatic pageWrap;
        int i;
        setAddr(16'h0100);
        for (i = 0; i < 130; i++) send(i[7:0], 1'b1);
        see_bus_master_i.stop();
        waitIdle();
        readBack(16'h0100, 24'h808102, 3);
    endtask
    task automatic selectScan;
        int s;
        for (s = 0; s < 8; s++) begin
            see_bus_master_i.start();
            send({4'hA, s[2:0], 1'b0}, s[2:0] == SEL);
            see_bus_master_i.stop();
        end
        see_bus_master_i.start();
        send({4'hB, SEL, 1'b0}, 1'b0);
        see_bus_master_i.stop();
    endtask
    task automatic protectWrite;
        @(posedge sys_clk) #1 writeProtect = 1'b1;
        repeat (4) @(posedge sys_clk);
        setAddr(16'h0100);
        send(8'hEE, 1'b1);
        see_bus_master_i.stop();
        repeat (10) @(posedge sys_clk);
        #1 check({7'h00, writeBusy}, 8'h00);
        #1 writeProtect = 1'b0;
        repeat (4) @(posedge sys_clk);
        readBack(16'h0100, 24'h800000, 1);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = !sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            printVerdict();
        end
    end
    initial begin
        reset_n = 1'b0;
        writeProtect = 1'b0;
        // a floating strap reads low; the bench ties every strap explicitly
        deviceSelectPins = SEL;
        repeat (10) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 check({standby, writeBusy, 6'h00}, 8'h80);
        see_bus_master_i.recover();
        byteWritePoll();
        pageWrap();
        selectScan();
        protectWrite();
        printVerdict();
    end
endmodule
